// [serial_port_defs.svh]
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
`define CLK_HZ 27'h2625A00
`define FIFO_DEPTH 7'h40
`define FIFO_HALF 7'h20
`define FIFO_HALF_M1 7'h1F
`define FIFO_HALF_P1 7'h21
`define OFS_DATA 5'h00
`define OFS_CTRL 5'h04
`define OFS_RATE 5'h08
`define OFS_STAT 5'h0C
`define OFS_ISTS 8'h40
`define OFS_IMASK 8'h44
`define CTRL_SYNC 0
`define CTRL_EXTCLK 1
`define CTRL_RS423 2
`define CTRL_FAST 3
`define CTRL_RTS 4
`define CTRL_DTR 5
`define CTRL_RATE_LSB 8
`define CTRL_RATE_MSB 12
`define CTRL_MASK 32'h00001F3F
`define CTRL_RESET 32'h00000A00
`define RATE_RESET 19'h0FA00
`define SYNC_MIN 19'h0C350
`define SYNC_MAX 19'h3E800
`define IRQ_RX 0
`define IRQ_TX 1
`define IRQ_MODEM 2
`define IRQ_STRIDE 4
`endif

// [serial_port_pkg.sv]
package serial_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } frame_state_e;
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_DATA = 3'b001,
    SEL_CTRL = 3'b010,
    SEL_RATE = 3'b011,
    SEL_STAT = 3'b100,
    SEL_ISTS = 3'b101,
    SEL_IMASK = 3'b110
  } reg_sel_e;
endpackage : serial_port_pkg

// [serial_channel.sv]
`include "serial_port_defs.svh"
module serial_channel (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sync_mode_in,
  input wire logic ext_clk_sel_in,
  input wire logic [18:0] rate_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_take_out,
  output logic [7:0] rx_data_out,
  output logic rx_push_out,
  input wire logic ext_clk_in,
  input wire logic rxd_in,
  output logic sclk_out,
  output logic txd_out
);
  logic [1:0] meta_reg, meta_next, pin_reg, pin_next;
  logic ck_prev_reg, ck_prev_next, sclk_reg, sclk_next;
  logic [26:0] acc_reg, acc_next, sum;
  logic tick, ck, rise, fall, tstep, rstep;
  serial_port_pkg::frame_state_e tst_reg, tst_next, rst_reg, rst_next;
  logic [7:0] tsh_reg, tsh_next, rsh_reg, rsh_next, rdat_reg, rdat_next;
  logic [2:0] tcnt_reg, tcnt_next, rcnt_reg, rcnt_next;
  logic [3:0] tph_reg, tph_next, rph_reg, rph_next;
  logic txd_reg, txd_next, push_reg, push_next;

  // The accumulator adds 16x the rate (2x in sync) each cycle and wraps at the clock rate,
  // so every rate, 110 included, is exact on average.
  always_comb begin
    meta_next = {ext_clk_in, rxd_in};
    pin_next = meta_reg;
    sum = acc_reg + (sync_mode_in ? {7'h00, rate_in, 1'b0}
                                  : {4'h0, rate_in, 4'h0});
    tick = (sum >= `CLK_HZ);
    acc_next = tick ? sum - `CLK_HZ : sum;
    sclk_next = sclk_reg ^ (tick & sync_mode_in & ~ext_clk_sel_in);
    ck = ext_clk_sel_in ? pin_reg[1] : sclk_reg;
    ck_prev_next = ck;
    rise = ck & ~ck_prev_reg;
    fall = ~ck & ck_prev_reg;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta_reg <= 2'h1;
      pin_reg <= 2'h1;
      acc_reg <= 27'h0000000;
      sclk_reg <= 1'b0;
      ck_prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      pin_reg <= pin_next;
      acc_reg <= acc_next;
      sclk_reg <= sclk_next;
      ck_prev_reg <= ck_prev_next;
    end
  end

  // Transmit: start, eight data bits, stop in async; a gapless stream in sync.
  always_comb begin
    tst_next = tst_reg;
    tsh_next = tsh_reg;
    tcnt_next = tcnt_reg;
    txd_next = txd_reg;
    tx_take_out = 1'b0;
    tph_next = tick ? tph_reg + 4'h1 : tph_reg;
    tstep = sync_mode_in ? fall : (tick && tph_reg == 4'hF);
    case (tst_reg)
      serial_port_pkg::ST_IDLE: begin
        txd_next = 1'b1;
        if (tx_valid_in && (sync_mode_in ? fall : tick)) begin
          tx_take_out = 1'b1;
          tcnt_next = 3'h0;
          tph_next = 4'h0;
          if (sync_mode_in) begin
            txd_next = tx_data_in[0];
            tsh_next = {1'b0, tx_data_in[7:1]};
            tst_next = serial_port_pkg::ST_DATA;
          end else begin
            txd_next = 1'b0;
            tsh_next = tx_data_in;
            tst_next = serial_port_pkg::ST_START;
          end
        end
      end
      serial_port_pkg::ST_START: begin
        if (tstep) begin
          txd_next = tsh_reg[0];
          tsh_next = {1'b0, tsh_reg[7:1]};
          tst_next = serial_port_pkg::ST_DATA;
        end
      end
      serial_port_pkg::ST_DATA: begin
        if (tstep && tcnt_reg != 3'h7) begin
          txd_next = tsh_reg[0];
          tsh_next = {1'b0, tsh_reg[7:1]};
          tcnt_next = tcnt_reg + 3'h1;
        end else if (tstep && sync_mode_in && tx_valid_in) begin
          tx_take_out = 1'b1;
          txd_next = tx_data_in[0];
          tsh_next = {1'b0, tx_data_in[7:1]};
          tcnt_next = 3'h0;
        end else if (tstep) begin
          txd_next = 1'b1;
          tst_next = sync_mode_in ? serial_port_pkg::ST_IDLE
                                  : serial_port_pkg::ST_STOP;
        end
      end
      serial_port_pkg::ST_STOP: begin
        if (tstep) begin
          tst_next = serial_port_pkg::ST_IDLE;
        end
      end
      default: tst_next = serial_port_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tst_reg <= serial_port_pkg::ST_IDLE;
      tsh_reg <= 8'h00;
      tcnt_reg <= 3'h0;
      tph_reg <= 4'h0;
      txd_reg <= 1'b1;
    end else begin
      tst_reg <= tst_next;
      tsh_reg <= tsh_next;
      tcnt_reg <= tcnt_next;
      tph_reg <= tph_next;
      txd_reg <= txd_next;
    end
  end

  // Receive: async samples mid-bit at 16x; sync samples each rising edge.
  always_comb begin
    rst_next = rst_reg;
    rsh_next = rsh_reg;
    rcnt_next = rcnt_reg;
    rdat_next = rdat_reg;
    push_next = 1'b0;
    rph_next = tick ? rph_reg + 4'h1 : rph_reg;
    rstep = tick && rph_reg == 4'hF;
    if (sync_mode_in) begin
      rst_next = serial_port_pkg::ST_IDLE;
      if (rise) begin
        rsh_next = {pin_reg[0], rsh_reg[7:1]};
        rcnt_next = rcnt_reg + 3'h1;
        if (rcnt_reg == 3'h7) begin
          rdat_next = {pin_reg[0], rsh_reg[7:1]};
          push_next = 1'b1;
        end
      end
    end else begin
      case (rst_reg)
        serial_port_pkg::ST_IDLE: begin
          if (!pin_reg[0]) begin
            rst_next = serial_port_pkg::ST_START;
            rph_next = 4'h0;
          end
        end
        serial_port_pkg::ST_START: begin
          if (tick && rph_reg == 4'h7) begin
            rph_next = 4'h0;
            rcnt_next = 3'h0;
            rst_next = pin_reg[0] ? serial_port_pkg::ST_IDLE
                                  : serial_port_pkg::ST_DATA;
          end
        end
        serial_port_pkg::ST_DATA: begin
          if (rstep) begin
            rsh_next = {pin_reg[0], rsh_reg[7:1]};
            rcnt_next = rcnt_reg + 3'h1;
            if (rcnt_reg == 3'h7) begin
              rst_next = serial_port_pkg::ST_STOP;
            end
          end
        end
        serial_port_pkg::ST_STOP: begin
          if (rstep) begin
            rst_next = serial_port_pkg::ST_IDLE;
            rdat_next = rsh_reg;
            push_next = pin_reg[0];
          end
        end
        default: rst_next = serial_port_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rst_reg <= serial_port_pkg::ST_IDLE;
      rsh_reg <= 8'h00;
      rcnt_reg <= 3'h0;
      rph_reg <= 4'h0;
      rdat_reg <= 8'h00;
      push_reg <= 1'b0;
    end else begin
      rst_reg <= rst_next;
      rsh_reg <= rsh_next;
      rcnt_reg <= rcnt_next;
      rph_reg <= rph_next;
      rdat_reg <= rdat_next;
      push_reg <= push_next;
    end
  end

  assign rx_data_out = rdat_reg;
  assign rx_push_out = push_reg;
  assign sclk_out = sclk_reg;
  assign txd_out = txd_reg;
endmodule : serial_channel

// [dual_sync_async_serial_port.sv]
// The register addresses and the APB slave port were decided locally.
`include "serial_port_defs.svh"
// Operation
// - Two independent channels, each with own pins.
// - Each channel sync or async, full modem lines.
// - 64-byte receive and transmit buffers per channel.
// - Interrupt when buffer level reaches 32 bytes.
// - Twenty async rates from 50 to 460800.
// - Async rates exact; 110 within one percent.
// - Sync internal clock 50 to 256 Kbaud.
// - Internal sync clock within one percent.
// - External sync bit clock up to 384 Kbaud.
// - Software selects RS-232 or RS-423 per channel.
// - Line standard resets to RS-232.
// - Software slew control: fast above 100 Kbaud.
// - All host access over the register bus.
module dual_sync_async_serial_port (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out,
  input wire logic [1:0] rxd_in,
  output logic [1:0] txd_out,
  input wire logic [1:0] ext_clk_in,
  output logic [1:0] sclk_out,
  output logic [1:0] rts_out,
  output logic [1:0] dtr_out,
  input wire logic [1:0] cts_in,
  input wire logic [1:0] dsr_in,
  input wire logic [1:0] dcd_in,
  input wire logic [1:0] ri_in,
  output logic [1:0] rs423_sel_out,
  output logic [1:0] fast_slew_out
);
  logic [1:0][31:0] ctrl_reg, ctrl_next;
  logic [1:0][18:0] rate_reg, rate_next, rate_sel;
  logic [7:0] ists_reg, ists_next, imask_reg, imask_next, ev, w1c;
  logic [1:0][63:0][7:0] rxm_reg, rxm_next, txm_reg, txm_next;
  logic [1:0][5:0] rxw_reg, rxw_next, rxr_reg, rxr_next;
  logic [1:0][5:0] txw_reg, txw_next, txr_reg, txr_next;
  logic [1:0][6:0] rxc_reg, rxc_next, txc_reg, txc_next;
  logic [31:0] prdata_reg, prdata_next;
  logic perr_reg, perr_next, popok_reg, popok_next;
  logic [1:0][3:0] mm_reg, mm_next, ms_reg, ms_next, mp_reg, mp_next;
  logic [1:0] take, chan_push, tx_push, rx_push, rx_pop;
  logic [1:0][7:0] chan_byte;
  logic setup, access, ch;
  serial_port_pkg::reg_sel_e sel;

  function automatic serial_port_pkg::reg_sel_e reg_code(
      input logic [7:0] a);
    serial_port_pkg::reg_sel_e r;
    r = serial_port_pkg::SEL_NONE;
    if (a == `OFS_ISTS) begin
      r = serial_port_pkg::SEL_ISTS;
    end else if (a == `OFS_IMASK) begin
      r = serial_port_pkg::SEL_IMASK;
    end else if (a[7:6] != 2'h0) begin
      r = serial_port_pkg::SEL_NONE;
    end else if (a[4:0] == `OFS_DATA) begin
      r = serial_port_pkg::SEL_DATA;
    end else if (a[4:0] == `OFS_CTRL) begin
      r = serial_port_pkg::SEL_CTRL;
    end else if (a[4:0] == `OFS_RATE) begin
      r = serial_port_pkg::SEL_RATE;
    end else if (a[4:0] == `OFS_STAT) begin
      r = serial_port_pkg::SEL_STAT;
    end
    return r;
  endfunction : reg_code

  // Out-of-range indexes fall back to 9600 baud.
  function automatic logic [18:0] async_baud(input logic [4:0] idx);
    logic [18:0] b;
    case (idx)
      5'h00: b = 19'h00032;
      5'h01: b = 19'h0004B;
      5'h02: b = 19'h0006E;
      5'h03: b = 19'h000C8;
      5'h04: b = 19'h0012C;
      5'h05: b = 19'h00258;
      5'h06: b = 19'h004B0;
      5'h07: b = 19'h00708;
      5'h08: b = 19'h00960;
      5'h09: b = 19'h012C0;
      5'h0B: b = 19'h04B00;
      5'h0C: b = 19'h09600;
      5'h0D: b = 19'h0E100;
      5'h0E: b = 19'h12C00;
      5'h0F: b = 19'h1C200;
      5'h10: b = 19'h25800;
      5'h11: b = 19'h38400;
      5'h12: b = 19'h4B000;
      5'h13: b = 19'h70800;
      default: b = 19'h02580;
    endcase
    return b;
  endfunction : async_baud

  function automatic logic [18:0] sync_clamp(input logic [18:0] r);
    logic [18:0] c;
    c = r;
    if (r < `SYNC_MIN) begin
      c = `SYNC_MIN;
    end else if (r > `SYNC_MAX) begin
      c = `SYNC_MAX;
    end
    return c;
  endfunction : sync_clamp

  assign setup = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign ch = paddr_in[5];
  assign sel = reg_code(paddr_in);

  always_comb begin
    ctrl_next = ctrl_reg;
    rate_next = rate_reg;
    imask_next = imask_reg;
    rxm_next = rxm_reg;
    txm_next = txm_reg;
    rxw_next = rxw_reg;
    rxr_next = rxr_reg;
    txw_next = txw_reg;
    txr_next = txr_reg;
    prdata_next = prdata_reg;
    perr_next = perr_reg;
    popok_next = popok_reg;
    ev = 8'h00;
    w1c = 8'h00;
    // Read data is latched in the setup cycle; a pop happens only if the
    // byte that was latched really existed.
    if (setup) begin
      prdata_next = 32'h00000000;
      perr_next = 1'b0;
      popok_next = 1'b0;
      if (sel == serial_port_pkg::SEL_DATA) begin
        prdata_next = {24'h000000, rxm_reg[ch][rxr_reg[ch]]};
        popok_next = (rxc_reg[ch] != 7'h00);
      end else if (sel == serial_port_pkg::SEL_CTRL) begin
        prdata_next = ctrl_reg[ch];
      end else if (sel == serial_port_pkg::SEL_RATE) begin
        prdata_next = {13'h0000, rate_reg[ch]};
      end else if (sel == serial_port_pkg::SEL_STAT) begin
        prdata_next = {12'h000, ms_reg[ch], 1'b0, txc_reg[ch], 1'b0,
                       rxc_reg[ch]};
      end else if (sel == serial_port_pkg::SEL_ISTS) begin
        prdata_next = {24'h000000, ists_reg};
      end else if (sel == serial_port_pkg::SEL_IMASK) begin
        prdata_next = {24'h000000, imask_reg};
      end else begin
        perr_next = 1'b1;
      end
    end
    if (access && pwrite_in) begin
      if (sel == serial_port_pkg::SEL_CTRL) begin
        ctrl_next[ch] = pwdata_in & `CTRL_MASK;
      end else if (sel == serial_port_pkg::SEL_RATE) begin
        rate_next[ch] = pwdata_in[18:0];
      end else if (sel == serial_port_pkg::SEL_ISTS) begin
        w1c = pwdata_in[7:0];
      end else if (sel == serial_port_pkg::SEL_IMASK) begin
        imask_next = pwdata_in[7:0];
      end
    end
    for (int c = 0; c < 2; c++) begin
      tx_push[c] = access && pwrite_in && ch == c[0] &&
                   sel == serial_port_pkg::SEL_DATA &&
                   txc_reg[c] < `FIFO_DEPTH;
      rx_pop[c] = access && !pwrite_in && ch == c[0] && popok_reg &&
                  sel == serial_port_pkg::SEL_DATA;
      rx_push[c] = chan_push[c] && rxc_reg[c] < `FIFO_DEPTH;
      if (tx_push[c]) begin
        txm_next[c][txw_reg[c]] = pwdata_in[7:0];
        txw_next[c] = txw_reg[c] + 6'h01;
      end
      if (take[c]) begin
        txr_next[c] = txr_reg[c] + 6'h01;
      end
      if (rx_push[c]) begin
        rxm_next[c][rxw_reg[c]] = chan_byte[c];
        rxw_next[c] = rxw_reg[c] + 6'h01;
      end
      if (rx_pop[c]) begin
        rxr_next[c] = rxr_reg[c] + 6'h01;
      end
      txc_next[c] = txc_reg[c] + {6'h00, tx_push[c]} - {6'h00, take[c]};
      rxc_next[c] = rxc_reg[c] + {6'h00, rx_push[c]} - {6'h00, rx_pop[c]};
      ev[c * `IRQ_STRIDE + `IRQ_RX] = rxc_reg[c] == `FIFO_HALF_M1 &&
                                      rxc_next[c] == `FIFO_HALF;
      ev[c * `IRQ_STRIDE + `IRQ_TX] = txc_reg[c] == `FIFO_HALF_P1 &&
                                      txc_next[c] == `FIFO_HALF;
      ev[c * `IRQ_STRIDE + `IRQ_MODEM] = ms_reg[c] != mp_reg[c];
    end
    // A new event in the same cycle as its clear keeps the bit set.
    ists_next = (ists_reg & ~w1c) | ev;
  end

  always_ff @(posedge clk_in) begin
    rxm_reg <= rxm_next;
    txm_reg <= txm_next;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_reg <= {2{`CTRL_RESET}};
      rate_reg <= {2{`RATE_RESET}};
      ists_reg <= 8'h00;
      imask_reg <= 8'h00;
      rxw_reg <= 12'h000;
      rxr_reg <= 12'h000;
      txw_reg <= 12'h000;
      txr_reg <= 12'h000;
      rxc_reg <= 14'h0000;
      txc_reg <= 14'h0000;
      prdata_reg <= 32'h00000000;
      perr_reg <= 1'b0;
      popok_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      rate_reg <= rate_next;
      ists_reg <= ists_next;
      imask_reg <= imask_next;
      rxw_reg <= rxw_next;
      rxr_reg <= rxr_next;
      txw_reg <= txw_next;
      txr_reg <= txr_next;
      rxc_reg <= rxc_next;
      txc_reg <= txc_next;
      prdata_reg <= prdata_next;
      perr_reg <= perr_next;
      popok_reg <= popok_next;
    end
  end

  // Modem status lines pass two flip-flops before change detection.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      mm_next[c] = {ri_in[c], dcd_in[c], dsr_in[c], cts_in[c]};
    end
    ms_next = mm_reg;
    mp_next = ms_reg;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mm_reg <= 8'h00;
      ms_reg <= 8'h00;
      mp_reg <= 8'h00;
    end else begin
      mm_reg <= mm_next;
      ms_reg <= ms_next;
      mp_reg <= mp_next;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : chan
    assign rate_sel[g] = ctrl_reg[g][`CTRL_SYNC]
        ? sync_clamp(rate_reg[g])
        : async_baud(ctrl_reg[g][`CTRL_RATE_MSB:`CTRL_RATE_LSB]);
    serial_channel u_chan (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .sync_mode_in(ctrl_reg[g][`CTRL_SYNC]),
      .ext_clk_sel_in(ctrl_reg[g][`CTRL_EXTCLK]),
      .rate_in(rate_sel[g]),
      .tx_data_in(txm_reg[g][txr_reg[g]]),
      .tx_valid_in(txc_reg[g] != 7'h00),
      .tx_take_out(take[g]),
      .rx_data_out(chan_byte[g]),
      .rx_push_out(chan_push[g]),
      .ext_clk_in(ext_clk_in[g]),
      .rxd_in(rxd_in[g]),
      .sclk_out(sclk_out[g]),
      .txd_out(txd_out[g])
    );
    assign rts_out[g] = ctrl_reg[g][`CTRL_RTS];
    assign dtr_out[g] = ctrl_reg[g][`CTRL_DTR];
    assign rs423_sel_out[g] = ctrl_reg[g][`CTRL_RS423];
    assign fast_slew_out[g] = ctrl_reg[g][`CTRL_FAST];
  end

  assign prdata_out = prdata_reg;
  assign pready_out = access;
  assign pslverr_out = access & perr_reg;
  assign irq_out = |(ists_reg & imask_reg);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence rx_cross_s;
    rxc_reg[1] == 7'h1F ##1 rxc_reg[1] == 7'h20;
  endsequence
  sequence tx_fall_s;
    txc_reg[0] == 7'h21 ##1 txc_reg[0] == 7'h20;
  endsequence
  sequence bad_setup_s;
    setup && sel == serial_port_pkg::SEL_NONE ##1 access;
  endsequence

  fifo_depth_a: assert property (
    rxc_reg[0] <= 7'h40 && txc_reg[0] <= 7'h40 && rxc_reg[1] <= 7'h40)
    else $error("buffer level above 64");
  rx_half_a: assert property (
    rx_cross_s |-> ists_reg[4] ##1 ists_reg[4] || $past(w1c[4]))
    else $error("receive half full not flagged");
  tx_half_a: assert property (
    tx_fall_s |-> ists_reg[1])
    else $error("transmit half empty not flagged");
  sticky_hold_a: assert property (
    ists_reg[1] && !w1c[1] |=> ists_reg[1])
    else $error("sticky status bit lost");
  irq_mask_a: assert property (
    imask_reg == 8'h00
    |-> !irq_out)
    else $error("masked interrupt raised");
  line_reset_a: assert property (disable iff (1'b0)
    !reset_n_in ##1 reset_n_in |-> rs423_sel_out == 2'b00)
    else $error("line standard not RS-232 after reset");
  slew_write_a: assert property (
    access && pwrite_in && sel == serial_port_pkg::SEL_CTRL && !ch
    |=> fast_slew_out[0] == $past(pwdata_in[3]) &&
        rs423_sel_out[0] == $past(pwdata_in[2]))
    else $error("slew or line select not taken");
  unmapped_err_a: assert property (
    bad_setup_s |-> pslverr_out && pready_out)
    else $error("unmapped access not refused");
  sync_range_a: assert property (
    ctrl_reg[0][0] |-> rate_sel[0] >= 19'h0C350 && rate_sel[0] <= 19'h3E800)
    else $error("sync rate out of range");
  async_range_a: assert property (
    !ctrl_reg[1][0] |-> rate_sel[1] >= 19'h00032 && rate_sel[1] <= 19'h70800)
    else $error("async rate out of range");
endmodule : dual_sync_async_serial_port

// [serial_far_end.sv]
module serial_far_end (
  input wire logic txd_in,
  output logic [1:0] rxd_out,
  output logic [1:0] ext_clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam real BIT_NS = 1.0E9 / 460800.0;
  logic [7:0] got_q[$];
  logic [7:0] sh;
  initial begin
    rxd_out = 2'h3;
    ext_clk_out = 2'h0;
  end
  // Samples each async bit of channel 0 at its centre.
  always begin
    @(negedge txd_in);
    #(BIT_NS / 2.0);
    if (txd_in === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        sh[i] = txd_in;
      end
      #(BIT_NS);
      if (txd_in === 1'b1) got_q.push_back(sh);
    end
  end
  task automatic send_async(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_out[0] = fr[i];
      #(BIT_NS);
    end
  endtask : send_async
  // The bit clock runs only within the frame; data moves while it is low.
  task automatic send_sync(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rxd_out[1] = b[i];
      #100 ext_clk_out[1] = 1'b1;
      #100 ext_clk_out[1] = 1'b0;
    end
    rxd_out[1] = 1'b1;
  endtask : send_sync
endmodule : serial_far_end

// [dual_sync_async_serial_port_tb.sv]
module dual_sync_async_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } row_s;
  localparam int LIMIT = 80000;
  logic clk_in = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [1:0] rxd;
  logic [1:0] txd;
  logic [1:0] ext_clk;
  logic [1:0] sclk;
  logic [1:0] rs423;
  logic [1:0] fast;
  logic [1:0] rts;
  logic [1:0] dtr;
  logic [1:0] cts = 2'h0;
  logic [1:0] dcd = 2'h0;
  logic [31:0] rd;
  logic er;
  logic prev;
  int compares = 0;
  int miscompares = 0;
  int cycles = 0;
  int n;
  row_s rows [12];
  always #12.5 clk_in = ~clk_in;
  dual_sync_async_serial_port i_dut (.clk_in(clk_in),
    .reset_n_in(reset_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .irq_out(irq), .rxd_in(rxd), .txd_out(txd), .ext_clk_in(ext_clk),
    .sclk_out(sclk), .rts_out(rts), .dtr_out(dtr), .cts_in(cts),
    .dsr_in(2'h0), .dcd_in(dcd), .ri_in(2'h0), .rs423_sel_out(rs423),
    .fast_slew_out(fast));
  serial_far_end far (.txd_in(txd[0]), .rxd_out(rxd),
    .ext_clk_out(ext_clk));
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] g);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    rows[0] = '{8'h04, 1'b0, 32'h0, 32'h00000A00, 1'b0};
    rows[1] = '{8'h24, 1'b0, 32'h0, 32'h00000A00, 1'b0};
    rows[2] = '{8'h08, 1'b0, 32'h0, 32'h0000FA00, 1'b0};
    rows[3] = '{8'h44, 1'b0, 32'h0, 32'h0, 1'b0};
    rows[4] = '{8'h0C, 1'b0, 32'h0, 32'h0, 1'b0};
    rows[5] = '{8'h80, 1'b0, 32'h0, 32'h0, 1'b1};
    rows[6] = '{8'h04, 1'b1, 32'h130C, 32'h0, 1'b0};
    rows[7] = '{8'h24, 1'b1, 32'h0A08, 32'h0, 1'b0};
    rows[8] = '{8'h04, 1'b0, 32'h0, 32'h130C, 1'b0};
    rows[9] = '{8'h0C, 1'b1, 32'hFFFF, 32'h0, 1'b0};
    rows[10] = '{8'h0C, 1'b0, 32'h0, 32'h0, 1'b0};
    rows[11] = '{8'h90, 1'b1, 32'h1, 32'h0, 1'b1};
    repeat (20) @(posedge clk_in);
    reset_n <= 1'b1;
    chk("rs423_sel", 32'h0, 32'(rs423));
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk("prdata", rows[i].x, rd);
      chk("pslverr", 32'(rows[i].e), 32'(er));
    end
    chk("rs423_sel", 32'h1, 32'(rs423));
    chk("fast_slew", 32'h3, 32'(fast));
    $display("registers done");
    cts <= 2'h1;
    dcd <= 2'h2;
    repeat (4) @(posedge clk_in);
    apb(8'h40, 1'b0, 32'h0);
    chk("modem events", 32'h44, rd);
    chk("irq masked", 32'h0, 32'(irq));
    apb(8'h40, 1'b1, 32'h44);
    apb(8'h40, 1'b0, 32'h0);
    chk("events cleared", 32'h0, rd);
    apb(8'h24, 1'b1, 32'h30);
    @(posedge clk_in);
    chk("rts dtr", 32'hA, 32'({rts, dtr}));
    $display("modem done");
    apb(8'h00, 1'b1, 32'hA5);
    for (n = 0; n < 3000 && far.got_q.size() == 0; n++) @(posedge clk_in);
    chk("tx byte", 32'hA5, 32'(far.got_q[0]));
    far.send_async(8'h3C);
    apb(8'h00, 1'b0, 32'h0);
    chk("rx byte", 32'h3C, rd);
    $display("async done");
    apb(8'h44, 1'b1, 32'h2);
    for (n = 0; n < 70; n++) apb(8'h00, 1'b1, 32'(n));
    apb(8'h0C, 1'b0, 32'h0);
    chk("tx level full", 32'h40, 32'(rd[14:8]));
    for (n = 0; n < 40000 && irq !== 1'b1; n++) @(posedge clk_in);
    apb(8'h0C, 1'b0, 32'h0);
    chk("tx level half", 32'h20, 32'(rd[14:8]));
    repeat (50) @(posedge clk_in);
    chk("irq pending", 32'h1, 32'(irq));
    apb(8'h40, 1'b1, 32'h2);
    @(posedge clk_in);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("buffer done");
    apb(8'h24, 1'b1, 32'h3);
    far.send_sync(8'h96);
    apb(8'h20, 1'b0, 32'h0);
    chk("ext sync byte", 32'h96, rd);
    for (n = 0; n < 32; n++) far.send_sync(8'(n));
    apb(8'h40, 1'b0, 32'h0);
    chk("rx half event", 32'h10, rd);
    apb(8'h28, 1'b1, 32'h3E800);
    apb(8'h24, 1'b1, 32'h1);
    n = 0;
    prev = sclk[1];
    repeat (10000) begin
      @(posedge clk_in);
      if (sclk[1] === 1'b1 && prev === 1'b0) n++;
      prev = sclk[1];
    end
    chk("sclk edges 63..65", 32'h1, 32'(n inside {[63:65]}));
    $display("sync done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n <= 1'b1;
    chk("rs423 after reset", 32'h0, 32'(rs423));
    apb(8'h04, 1'b0, 32'h0);
    chk("ctrl after reset", 32'hA00, rd);
    $display("reset done");
    test_done();
  end
endmodule : dual_sync_async_serial_port_tb
